// File: core/ccm_pkg.sv
package ccm_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GMODE = 8'h04;
  localparam logic [7:0] A_RUN = 8'h08;
  localparam logic [7:0] A_OVF = 8'h0c;
  localparam logic [7:0] A_OVF_EN = 8'h10;
  localparam logic [7:0] A_MODE = 8'h20;
  localparam logic [7:0] A_UCFG = 8'h40;
  localparam logic [7:0] A_CNT = 8'h60;
  localparam logic [7:0] A_CMP_LO = 8'h80;
  localparam logic [7:0] A_CMP_HI = 8'ha0;
  localparam logic [7:0] A_STRIDE = 8'h04;
  // control_status_reg fields
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  // global_mode_reg fields
  localparam int GM_IDLE_BIT = 7;
  localparam int GM_WDT_BIT = 6;
  localparam int GM_SRC_LSB = 1;
  localparam int GM_OVF_IE_BIT = 0;
  // per_unit_run_reg fields
  localparam int RUN_PUM_BIT = 7;
  // Per-unit config fields
  localparam int UCFG_IDLE_BIT = 3;
  // module_mode_reg fields
  localparam int MD_ECOM = 6;
  localparam int MD_CAPP = 5;
  localparam int MD_CAPN = 4;
  localparam int MD_MAT = 3;
  localparam int MD_TOG = 2;
  localparam int MD_PWM = 1;
  localparam int MD_IE = 0;
  localparam int MD_PIN_LVL = 8;
  localparam int MD_PIN_FORCE = 9;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  // Timing: oscillator periods per peripheral cycle and high-byte delay
  localparam logic [3:0] PERIPH_LAST = 4'hb;
  localparam int HIGH_INC_DELAY = 2;
  // Byte values for the low and high bytes
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Clock source selections
  localparam logic [2:0] SRC_OSC12 = 3'h0;
  localparam logic [2:0] SRC_OSC4 = 3'h1;
  localparam logic [2:0] SRC_T0 = 3'h2;
  localparam logic [2:0] SRC_EXT = 3'h3;
  localparam logic [2:0] SRC_FAST4 = 3'h4;
  localparam logic [2:0] SRC_T1 = 3'h5;
  localparam logic [2:0] SRC_RSVD = 3'h6;
  localparam logic [2:0] SRC_BAUD = 3'h7;

  typedef struct packed {
    logic mode_we;
    logic lo_we;
    logic hi_we;
    logic [9:0] data;
  } ccm_wr_t;
endpackage

// File: core/ccm_counter.sv
`timescale 1ns/1ps
module ccm_counter
  import ccm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic run,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] count,
  output logic low_roll,
  output logic ovf
);
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [HIGH_INC_DELAY-1:0] dly_q;
  logic ovf_q;

  assign low_roll = run && tick && (lo_q == BYTE_MAX);
  assign count = {hi_q, lo_q};
  assign ovf = ovf_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lo_q <= RST_COUNT[7:0];
    end else if (wr_en && !run) begin
      lo_q <= wr_data[7:0];
    end else if (run && tick) begin
      lo_q <= lo_q + 8'h01;
    end
  end

  // High byte follows a low-byte wrap after a fixed delay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[HIGH_INC_DELAY-2:0], low_roll};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= RST_COUNT[15:8];
    end else if (wr_en && !run) begin
      hi_q <= wr_data[15:8];
    end else if (dly_q[HIGH_INC_DELAY-1]) begin
      hi_q <= hi_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= dly_q[HIGH_INC_DELAY-1] && (hi_q == BYTE_MAX);
    end
  end
endmodule

// File: core/ccm_module.sv
`timescale 1ns/1ps
module ccm_module
  import ccm_pkg::*;
#(
  parameter bit IS_WDT = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ccm_pkg::ccm_wr_t wr,
  input wire logic [15:0] count,
  input wire logic cmp_strobe,
  input wire logic low_roll,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic [7:0] mode,
  output logic [15:0] cmp,
  output logic flag_set,
  output logic wdt_match
);
  logic [6:0] mode_q;
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic pin_q;
  logic s1_q, s2_q, s3_q;
  logic eq_seen_q;
  logic cap_mode, cmp_mode, pwm_mode, edge_hit, eq, match;

  assign mode = {1'b0, mode_q};
  assign cmp = {hi_q, lo_q};
  assign pin_out = pin_q;
  assign cap_mode = (mode_q[MD_CAPP] | mode_q[MD_CAPN]) & ~mode_q[MD_MAT] & ~mode_q[MD_TOG]
                    & ~mode_q[MD_PWM];
  // Other bit patterns do nothing defined
  assign cmp_mode = mode_q[MD_ECOM] & mode_q[MD_MAT] & ~mode_q[MD_PWM] & ~mode_q[MD_CAPP]
                    & ~mode_q[MD_CAPN];
  assign pwm_mode = mode_q[MD_ECOM] & mode_q[MD_PWM] & ~mode_q[MD_MAT] & ~mode_q[MD_TOG]
                    & ~mode_q[MD_CAPP] & ~mode_q[MD_CAPN];
  assign pin_oe = (cmp_mode & mode_q[MD_TOG]) | pwm_mode;
  assign edge_hit = cap_mode & ((mode_q[MD_CAPP] & s2_q & ~s3_q)
                    | (mode_q[MD_CAPN] & ~s2_q & s3_q));
  assign eq = (count == cmp);
  // One event per arrival at the compare value, sampled at the compare rate
  assign match = cmp_mode & cmp_strobe & eq & ~eq_seen_q;
  assign flag_set = edge_hit | match;
  assign wdt_match = IS_WDT & match;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eq_seen_q <= 1'b0;
    end else if (cmp_strobe) begin
      eq_seen_q <= eq;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= RST_BYTE[6:0];
    end else if (wr.mode_we) begin
      mode_q <= wr.data[6:0];
    end else if (wr.lo_we) begin
      mode_q[MD_ECOM] <= 1'b0;
    end else if (wr.hi_we) begin
      mode_q[MD_ECOM] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lo_q <= RST_BYTE;
    end else if (edge_hit) begin
      lo_q <= count[7:0];
    end else if (wr.lo_we) begin
      lo_q <= wr.data[7:0];
    end else if (pwm_mode && low_roll) begin
      lo_q <= hi_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= RST_BYTE;
    end else if (edge_hit) begin
      hi_q <= count[15:8];
    end else if (wr.hi_we) begin
      hi_q <= wr.data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b0;
    end else if (wr.mode_we && wr.data[MD_PIN_FORCE]) begin
      pin_q <= wr.data[MD_PIN_LVL];
    end else if (pwm_mode && low_roll) begin
      pin_q <= (hi_q == BYTE_ZERO);
    end else if (pwm_mode) begin
      pin_q <= (count[7:0] >= lo_q);
    end else if (match && mode_q[MD_TOG]) begin
      pin_q <= ~pin_q;
    end
  end
endmodule

// File: core/ccm_top.sv
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module ccm_top
  import ccm_pkg::*;
#(
  parameter int NUM_UNITS = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_idle,
  input wire logic ext_counter_mode,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic baud_tick,
  input wire logic ext_count_tick,
  input wire logic [NUM_UNITS-1:0] module_pin_in,
  output logic [NUM_UNITS-1:0] module_pin_out,
  output logic [NUM_UNITS-1:0] module_pin_oe,
  output logic irq_general,
  output logic [NUM_UNITS-1:1] irq_module,
  output logic device_reset_req
);
  import ccm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter check

  if (NUM_UNITS < 2 || NUM_UNITS > 8) begin : g_bad
    $error("NUM_UNITS must lie between 2 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata_d;
  logic take;
  logic [7:0] wdat;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wdat = hwdata[7:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Global registers

  logic [NUM_UNITS-1:0] mflag_q;
  logic ovf_flag_q;
  logic run_q;
  logic [7:0] gmode_q;
  logic pum_q;
  logic [NUM_UNITS-1:0] urun_q;
  logic [NUM_UNITS-1:0] uovf_q;
  logic [NUM_UNITS-1:0] uovf_en_q;
  logic [3:0] ucfg_q [NUM_UNITS];
  logic [NUM_UNITS-1:0] flag_set;
  logic [NUM_UNITS-1:0] cnt_ovf;
  logic [NUM_UNITS-1:0] wdt_match;
  logic [NUM_UNITS-1:0] irq_en;
  logic per_unit;
  logic we_ctrl, we_gmode, we_run, we_ovf, we_ovf_en;

  assign we_ctrl = wr_pend_q && (wr_addr_q == A_CTRL);
  assign we_gmode = wr_pend_q && (wr_addr_q == A_GMODE);
  assign we_run = wr_pend_q && (wr_addr_q == A_RUN);
  assign we_ovf = wr_pend_q && (wr_addr_q == A_OVF);
  assign we_ovf_en = wr_pend_q && (wr_addr_q == A_OVF_EN);
  assign per_unit = pum_q && !ext_counter_mode;

  // Flags: software writes, hardware only sets; a set wins over a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mflag_q <= '0;
    end else if (we_ctrl) begin
      mflag_q <= hwdata[NUM_UNITS-1:0] | flag_set;
    end else begin
      mflag_q <= mflag_q | flag_set;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_flag_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (we_ctrl) begin
        ovf_flag_q <= wdat[CTRL_OVF_BIT] | (cnt_ovf[0] & !per_unit);
        run_q <= wdat[CTRL_RUN_BIT];
      end else begin
        ovf_flag_q <= ovf_flag_q | (cnt_ovf[0] & !per_unit);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gmode_q <= RST_BYTE;
    end else if (we_gmode) begin
      gmode_q <= wdat;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pum_q <= 1'b0;
      urun_q <= '0;
    end else if (we_run) begin
      pum_q <= wdat[RUN_PUM_BIT];
      urun_q <= hwdata[NUM_UNITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uovf_q <= '0;
    end else if (we_ovf) begin
      uovf_q <= hwdata[NUM_UNITS-1:0] | (cnt_ovf & {NUM_UNITS{per_unit}});
    end else begin
      uovf_q <= uovf_q | (cnt_ovf & {NUM_UNITS{per_unit}});
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uovf_en_q <= '0;
    end else if (we_ovf_en) begin
      uovf_en_q <= hwdata[NUM_UNITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler: one peripheral cycle is twelve oscillator periods

  logic [3:0] presc_q;
  logic tick12, tick4, tick2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_q <= 4'h0;
    end else if (presc_q == PERIPH_LAST) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end

  assign tick12 = (presc_q == PERIPH_LAST);
  assign tick4 = (presc_q[1:0] == 2'h3);
  assign tick2 = presc_q[0];

  function automatic logic src_pulse(input logic [2:0] sel, input logic t12, input logic t4,
                                     input logic t0, input logic ext, input logic t1,
                                     input logic baud);
    logic p;
    p = 1'b0;
    unique case (sel)
      SRC_OSC12: p = t12;
      SRC_OSC4: p = t4;
      SRC_T0: p = t0;
      SRC_EXT: p = ext;
      SRC_FAST4: p = t4;
      SRC_T1: p = t1;
      SRC_RSVD: p = 1'b0;
      SRC_BAUD: p = baud;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Units: counter plus compare/capture module

  logic [15:0] count [NUM_UNITS];
  logic [15:0] cmp [NUM_UNITS];
  logic [7:0] mode [NUM_UNITS];
  logic [NUM_UNITS-1:0] low_roll;
  logic [NUM_UNITS-1:0] run;

  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    localparam logic [7:0] OFS = 8'(i * 4);
    logic [2:0] sel;
    logic tick;
    logic cnt_we;
    logic [15:0] tb;
    logic tb_roll;
    ccm_wr_t wr;

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ucfg_q[i] <= 4'h0;
      end else if (wr_pend_q && (wr_addr_q == A_UCFG + OFS)) begin
        ucfg_q[i] <= wdat[3:0];
      end
    end

    assign sel = per_unit ? ucfg_q[i][2:0] : {1'b0, gmode_q[GM_SRC_LSB+1:GM_SRC_LSB]};
    assign tick = src_pulse(sel, tick12, tick4, timer0_ovf, ext_count_tick, timer1_ovf,
                            baud_tick);
    if (i == 0) begin : g_shared
      assign run[i] = per_unit ? (urun_q[i] && !(cpu_idle && ucfg_q[i][UCFG_IDLE_BIT]))
                    : (run_q && !(cpu_idle && gmode_q[GM_IDLE_BIT]));
    end else begin : g_own
      assign run[i] = per_unit && urun_q[i] && !(cpu_idle && ucfg_q[i][UCFG_IDLE_BIT]);
    end
    assign cnt_we = wr_pend_q && (wr_addr_q == A_CNT + OFS);
    assign tb = per_unit ? count[i] : count[0];
    assign tb_roll = per_unit ? low_roll[i] : low_roll[0];
    assign irq_en[i] = mode[i][MD_IE];
    assign wr.mode_we = wr_pend_q && (wr_addr_q == A_MODE + OFS);
    assign wr.lo_we = wr_pend_q && (wr_addr_q == A_CMP_LO + OFS);
    assign wr.hi_we = wr_pend_q && (wr_addr_q == A_CMP_HI + OFS);
    assign wr.data = hwdata[9:0];

    ccm_counter u_cnt (
      .clk(clk),
      .rstn(rstn),
      .tick(tick),
      .run(run[i]),
      .wr_en(cnt_we),
      .wr_data(hwdata[15:0]),
      .count(count[i]),
      .low_roll(low_roll[i]),
      .ovf(cnt_ovf[i])
    );

    ccm_module #(
      .IS_WDT(i == NUM_UNITS - 1)
    ) u_mod (
      .clk(clk),
      .rstn(rstn),
      .wr(wr),
      .count(tb),
      .cmp_strobe(tick4),
      .low_roll(tb_roll),
      .pin_in(module_pin_in[i]),
      .pin_out(module_pin_out[i]),
      .pin_oe(module_pin_oe[i]),
      .mode(mode[i]),
      .cmp(cmp[i]),
      .flag_set(flag_set[i]),
      .wdt_match(wdt_match[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt requests and watchdog reset

  always_comb begin
    if (per_unit) begin
      irq_general = (mflag_q[0] & irq_en[0]) | |(uovf_q & uovf_en_q);
      irq_module = mflag_q[NUM_UNITS-1:1] & irq_en[NUM_UNITS-1:1];
    end else begin
      irq_general = |(mflag_q & irq_en) | (ovf_flag_q & gmode_q[GM_OVF_IE_BIT]);
      irq_module = '0;
    end
  end

  // Pulse fed to the device reset tree like the external reset pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= wdt_match[NUM_UNITS-1] && gmode_q[GM_WDT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux, decoded in the address phase

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (haddr[7:0])
      A_CTRL: begin
        rdata_d[NUM_UNITS-1:0] = mflag_q;
        rdata_d[CTRL_OVF_BIT] = ovf_flag_q;
        rdata_d[CTRL_RUN_BIT] = run_q;
      end
      A_GMODE: rdata_d[7:0] = gmode_q;
      A_RUN: begin
        rdata_d[NUM_UNITS-1:0] = urun_q;
        rdata_d[RUN_PUM_BIT] = pum_q;
      end
      A_OVF: rdata_d[NUM_UNITS-1:0] = uovf_q;
      A_OVF_EN: rdata_d[NUM_UNITS-1:0] = uovf_en_q;
      default: begin
        for (int k = 0; k < NUM_UNITS; k++) begin
          if (haddr[7:0] == A_MODE + 8'(k * 4)) begin
            rdata_d[7:0] = mode[k];
            rdata_d[MD_PIN_LVL] = module_pin_out[k];
          end
          if (haddr[7:0] == A_UCFG + 8'(k * 4)) begin
            rdata_d[3:0] = ucfg_q[k];
          end
          if (haddr[7:0] == A_CNT + 8'(k * 4)) begin
            rdata_d[15:0] = count[k];
          end
          if (haddr[7:0] == A_CMP_LO + 8'(k * 4)) begin
            rdata_d[7:0] = cmp[k][7:0];
          end
          if (haddr[7:0] == A_CMP_HI + 8'(k * 4)) begin
            rdata_d[7:0] = cmp[k][15:8];
          end
        end
      end
    endcase
  end
endmodule

// File: verif/ccm_partner.sv
`timescale 1ns/1ps
module ccm_partner #(
  parameter int NUM_UNITS = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick_en,
  input wire logic [NUM_UNITS-1:0] drv,
  input wire logic [NUM_UNITS-1:0] pin_out,
  input wire logic [NUM_UNITS-1:0] pin_oe,
  output logic [NUM_UNITS-1:0] pin_in,
  output logic t0,
  output logic t1,
  output logic baud,
  output logic ext
);
  logic [3:0] div_q;
  // The module wins the pin where it drives; elsewhere the event source sets it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  // One-cycle source pulses, silent unless the bench enables them
  assign t0 = tick_en && div_q == 4'h3;
  assign t1 = tick_en && div_q == 4'h7;
  assign baud = tick_en && div_q == 4'hb;
  assign ext = tick_en && div_q == 4'hf;
endmodule

// File: verif/ccm_assertions.sv
`timescale 1ns/1ps
module ccm_assertions
  import ccm_pkg::*;
#(
  parameter int NUM_UNITS = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ext_counter_mode,
  input wire logic [NUM_UNITS-1:0] module_pin_out,
  input wire logic [NUM_UNITS-1:0] module_pin_oe,
  input wire logic [NUM_UNITS-1:1] irq_module,
  input wire logic device_reset_req
);
  logic rd_take;
  logic run_wr_q;
  logic pum_q;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  // Tracks the unit-mode bit as software last wrote it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_wr_q <= 1'b0;
      pum_q <= 1'b0;
    end else begin
      run_wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == A_RUN;
      if (run_wr_q) begin
        pum_q <= hwdata[RUN_PUM_BIT];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////////
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  chk_rdata_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (rd_take && haddr[7:0] == 8'hfc |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_upper: assert property (hrdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_ext_override: assert property (ext_counter_mode && $past(ext_counter_mode)
    |-> irq_module == '0)
    else $error("unit interrupt in external counter mode");
  chk_unit_irq_mode: assert property (irq_module != '0 |-> pum_q)
    else $error("unit interrupt outside unit mode");
  chk_wdt_single: assert property (device_reset_req |=> !device_reset_req [*3])
    else $error("watchdog reset not a single pulse");
  chk_release_quiet: assert property (!$past(rstn)
    |-> !device_reset_req && irq_module == '0 && module_pin_oe == '0)
    else $error("outputs active right after reset");
  cover property (device_reset_req);
  cover property (irq_module != '0);
  cover property ($rose(module_pin_out[2]));
  cover property (rd_take && haddr[7:0] == 8'hfc);
endmodule

bind ccm_top ccm_assertions #(.NUM_UNITS(NUM_UNITS)) u_chk (
  .clk(clk),
  .rstn(rstn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .ext_counter_mode(ext_counter_mode),
  .module_pin_out(module_pin_out),
  .module_pin_oe(module_pin_oe),
  .irq_module(irq_module),
  .device_reset_req(device_reset_req)
);

// File: verif/ccm_tb.sv
`timescale 1ns/1ps
module tb;
  import ccm_pkg::*;
  logic clk, rstn, hsel, hwrite, cpu_idle, ext_mode, tick_en, hreadyout, hresp;
  logic t0, t1, baud, ext_tick, irq_gen, wdt_req, hit;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] drv, pin_in, pin_out, pin_oe;
  logic [4:1] irq_mod;
  logic [7:0] md [3];
  logic [7:0] ra [5];
  int errors, total_checks, wdt_n, hi_n;
  ccm_top #(.NUM_UNITS(5)) uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_idle(cpu_idle),
    .ext_counter_mode(ext_mode), .timer0_ovf(t0), .timer1_ovf(t1), .baud_tick(baud),
    .ext_count_tick(ext_tick), .module_pin_in(pin_in), .module_pin_out(pin_out),
    .module_pin_oe(pin_oe), .irq_general(irq_gen), .irq_module(irq_mod),
    .device_reset_req(wdt_req));
  ccm_partner #(.NUM_UNITS(5)) u_far (.clk(clk), .rstn(rstn), .tick_en(tick_en), .drv(drv),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .t0(t0), .t1(t1), .baud(baud),
    .ext(ext_tick));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wdt_req === 1'b1) wdt_n++;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(exp, rd, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(20000);
    errors++;
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, hsel, hwrite, cpu_idle, ext_mode, tick_en} = 6'h0;
    {haddr, hwdata, htrans, hsize, drv} = '0;
    md = '{8'h21, 8'h11, 8'h31};
    ra = '{A_CTRL, A_GMODE, A_RUN, A_CNT, 8'hfc};
    cyc(8);
    rstn <= 1'b1;
    hsize <= 3'h2;
    for (int i = 0; i < 5; i++) rchk(ra[i], 32'h0, "reset value");
    wr(A_CNT, 32'h1234);
    rchk(A_CNT, 32'h1234, "count load");
    wr(A_GMODE, 32'h06);
    wr(A_CTRL, 32'h40);
    wr(A_CNT, 32'h0);
    rchk(A_CNT, 32'h1234, "count write while running");
    for (int i = 0; i < 3; i++) begin
      wr(A_MODE, {24'h0, md[i]});
      for (int j = 0; j < 2; j++) begin
        v = 32'h0a00 + 32'(i * 16 + j);
        hit = md[i][5-j];
        wr(A_CTRL, 32'h0);
        wr(A_CNT, v);
        drv[0] <= (j == 0);
        cyc(8);
        rchk(A_CTRL, {31'h0, hit}, "capture flag");
        chk({31'h0, hit}, {31'h0, irq_gen}, "capture irq");
        if (hit) rchk(A_CMP_LO, {24'h0, v[7:0]}, "capture low");
        if (hit) rchk(A_CMP_HI, {24'h0, v[15:8]}, "capture high");
      end
    end
    wr(A_CTRL, 32'h0);
    wr(A_MODE, 32'h48);
    wr(A_CMP_LO, 32'h10);
    rchk(A_MODE, 32'h08, "compare off after low");
    wr(A_CMP_HI, 32'h0);
    rchk(A_MODE, 32'h48, "compare on after high");
    wr(A_CNT, 32'h0);
    wr(A_GMODE, 32'h02);
    wr(A_CTRL, 32'h40);
    cyc(100);
    rchk(A_CTRL, 32'h41, "match flag");
    wr(A_CTRL, 32'h0);
    wr(A_MODE, 32'h0);
    wr(A_CNT, 32'h0);
    wr(A_CMP_LO + 8'h04, 32'h20);
    wr(A_CMP_HI + 8'h04, 32'h0);
    wr(A_MODE + 8'h04, 32'h34c);
    cyc(1);
    chk(32'h3, {30'h0, pin_oe[1], pin_out[1]}, "forced pin");
    wr(A_CTRL, 32'h40);
    cyc(200);
    rchk(A_CTRL, 32'h42, "toggle flag");
    chk(32'h0, {31'h0, pin_out[1]}, "toggled pin");
    wr(A_CTRL, 32'h0);
    wr(A_MODE + 8'h04, 32'h0);
    wr(A_CNT, 32'h0);
    wr(A_CMP_LO + 8'h10, 32'h30);
    wr(A_CMP_HI + 8'h10, 32'h0);
    wr(A_MODE + 8'h10, 32'h48);
    wr(A_GMODE, 32'h42);
    wdt_n = 0;
    wr(A_CTRL, 32'h40);
    cyc(300);
    chk(32'h1, 32'(wdt_n), "watchdog resets");
    wr(A_CTRL, 32'h0);
    wr(A_GMODE, 32'h02);
    wr(A_CNT, 32'h0);
    wdt_n = 0;
    wr(A_CTRL, 32'h40);
    cyc(300);
    chk(32'h0, 32'(wdt_n), "watchdog gated");
    wr(A_CTRL, 32'h0);
    wr(A_MODE + 8'h10, 32'h0);
    wr(A_CNT, 32'h0);
    wr(A_CMP_LO + 8'h08, 32'h40);
    wr(A_CMP_HI + 8'h08, 32'hc0);
    wr(A_MODE + 8'h08, 32'h42);
    hi_n = 0;
    wr(A_CTRL, 32'h40);
    repeat (2100) begin
      @(posedge clk);
      if (pin_out[2] === 1'b1) hi_n++;
    end
    // High for 192 then 64 counts of 4 clocks; each rise lags its count by one clock
    chk(32'd1022, 32'(hi_n), "pwm high time");
    wr(A_CTRL, 32'h0);
    wr(A_MODE + 8'h08, 32'h0);
    wr(A_RUN, 32'h80);
    rchk(A_RUN, 32'h80, "unit mode");
    wr(A_CNT + 8'h04, 32'h0abc);
    wr(A_MODE + 8'h04, 32'h21);
    drv[1] <= 1'b1;
    cyc(8);
    rchk(A_CMP_LO + 8'h04, 32'hbc, "unit capture");
    chk(32'h1, {28'h0, irq_mod}, "unit irq line");
    chk(32'h0, {31'h0, irq_gen}, "general irq");
    ext_mode <= 1'b1;
    cyc(2);
    chk(32'h0, {28'h0, irq_mod}, "external override");
    ext_mode <= 1'b0;
    wr(A_CTRL, 32'h0);
    wr(A_MODE + 8'h04, 32'h0);
    wr(A_CNT + 8'h04, 32'hfff0);
    wr(A_UCFG + 8'h04, 32'h4);
    wr(A_UCFG + 8'h08, 32'h6);
    wr(A_OVF_EN, 32'h02);
    wr(A_RUN, 32'h86);
    cyc(100);
    rchk(A_OVF, 32'h02, "unit overflow");
    rchk(A_CNT + 8'h08, 32'h0, "reserved source");
    chk(32'h1, {31'h0, irq_gen}, "overflow irq");
    wr(A_OVF, 32'h0);
    cyc(1);
    chk(32'h0, {31'h0, irq_gen}, "overflow cleared");
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(1);
    rchk(A_RUN, 32'h0, "mode after reset");
    // Five sources counted over 192 clocks: 12 pulses of period 16, 16 of period 12
    wr(A_UCFG, 32'h2);
    wr(A_UCFG + 8'h04, 32'h3);
    wr(A_UCFG + 8'h08, 32'h5);
    wr(A_UCFG + 8'h0c, 32'h7);
    tick_en <= 1'b1;
    wr(A_RUN, 32'h9f);
    cyc(190);
    wr(A_RUN, 32'h80);
    for (int k = 0; k < 5; k++) begin
      rchk(A_CNT + 8'(k * 4), (k == 4) ? 32'd16 : 32'd12, "source count");
    end
    print_verdict();
  end
endmodule
